// [design/nv_access_pkg.sv]
// constants, offsets and types shared by the data nonvolatile access block
// Summary of operation
// - The address register picks one of 128 bytes with its low seven bits and bit 7 is ignored.
// - Only the low four control bits exist and the upper four always read as zero.
// - Setting the read or write strobe starts that operation and writing zero to a strobe does nothing.
// - Hardware clears the read or write strobe when its operation finishes.
// - A write cycle may start only while the write-allow bit is set.
// - The write-allow bit is clear after power-up.
// - An external or watchdog reset during a write sets the write-abort flag.
// - A reset that aborts a write clears the data and address registers.
// - Completion of a write sets the write-done flag in the peripheral flag register.
// - Hardware never clears the write-done flag; software clears it.
// - The unlock register has no storage and reads as all zeros.
// - Writes to the unlock register only serve the write start sequence.
// - A read finishes within one cycle, after which the read strobe clears.
package nv_access_pkg;

    localparam int BUS_AW = 8;
    localparam int MEM_DEPTH = 128;
    localparam int MEM_AW = 7;

    localparam logic [7:0] OFS_ADDRESS = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_UNLOCK = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;

    localparam int CTRL_RD = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_ALLOW = 2;
    localparam int CTRL_ABORT = 3;

    localparam int FLAG_W = 2;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_ABORT = 1;

    localparam logic [7:0] ADDRESS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 5000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {ST_IDLE, ST_WRITE} nv_state_t;
    typedef enum logic [1:0] {UL_LOCKED, UL_HALF, UL_OPEN} unlock_t;

endpackage

// [design/nv_pin_sync.sv]
// three-stage synchroniser for reset request pins
`timescale 1ns/100ps
module nv_pin_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // a bit moves only when the second and third stage agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level_o <= '0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            level_o <= (s2 & s3) | (level_o & (s2 | s3));
        end
    end
endmodule

// [design/nv_byte_mem.sv]
// byte array standing in for the nonvolatile data memory
`timescale 1ns/100ps
module nv_byte_mem #(
    parameter int DEPTH = nv_access_pkg::MEM_DEPTH,
    parameter int AW = nv_access_pkg::MEM_AW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];

    // cells start erased; reset never touches the array itself
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = nv_access_pkg::ERASED_BYTE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// [design/nv_access_ctrl.sv]
// register front end and write sequencer for the data nonvolatile memory
`timescale 1ns/100ps
module nv_access_ctrl #(
    parameter int WRITE_CYCLES = nv_access_pkg::WRITE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    output logic write_busy_o
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_req;
    logic [7:0] nv_address;
    logic [7:0] nv_data_reg;
    logic write_allow;
    logic rd_strobe;
    logic write_abort_flag;
    logic [1:0] peripheral_flag_reg;
    logic [1:0] flag_mask;
    logic [CW-1:0] cnt;
    logic [7:0] mem_rdata;
    nv_access_pkg::nv_state_t state;
    nv_access_pkg::nv_state_t next_state;
    nv_access_pkg::unlock_t unlock;
    nv_access_pkg::unlock_t next_unlock;

    nv_pin_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({wdt_reset_i, ext_reset_i}),
        .level_o(rst_req)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req = cyc_i & stb_i & ~ack_o;
    // a write lands at the edge where the master samples ack, never earlier
    wire wr_acc = ack_o & cyc_i & stb_i & we_i & sel_i[0];
    wire rd_acc = req & ~we_i;
    wire hit_address = adr_i == nv_access_pkg::OFS_ADDRESS;
    wire hit_control = adr_i == nv_access_pkg::OFS_CONTROL;
    wire hit_data = adr_i == nv_access_pkg::OFS_DATA;
    wire hit_unlock = adr_i == nv_access_pkg::OFS_UNLOCK;
    wire hit_flags = adr_i == nv_access_pkg::OFS_FLAGS;
    wire hit_mask = adr_i == nv_access_pkg::OFS_MASK;
    wire idle = state == nv_access_pkg::ST_IDLE;
    wire busy = state == nv_access_pkg::ST_WRITE;
    wire ctrl_write = wr_acc & hit_control;
    // status clears at the edge where the master takes the answer
    wire flags_read = ack_o & cyc_i & stb_i & ~we_i & hit_flags;

    ////////////////////////////////////////////////////////////////////////////////
    // write sequencing
    wire warm = |rst_req;
    wire abort = warm & busy;
    wire write_done = busy & (cnt == CNT_LAST) & ~warm;
    wire start_write = ctrl_write & dat_i[nv_access_pkg::CTRL_WR] & write_allow & idle
        & (unlock == nv_access_pkg::UL_OPEN) & ~warm;
    wire wr_bit = busy;

    always_comb begin
        next_state = state;
        case (state)
            nv_access_pkg::ST_IDLE: begin
                if (start_write) begin
                    next_state = nv_access_pkg::ST_WRITE;
                end
            end
            nv_access_pkg::ST_WRITE: begin
                if (write_done || warm) begin
                    next_state = nv_access_pkg::ST_IDLE;
                end
            end
            default: next_state = nv_access_pkg::ST_IDLE;
        endcase
    end

    // the key pair must come back to back; any control write spends it
    always_comb begin
        next_unlock = unlock;
        case (unlock)
            nv_access_pkg::UL_LOCKED,
            nv_access_pkg::UL_HALF,
            nv_access_pkg::UL_OPEN: begin
                if (warm || ctrl_write) begin
                    next_unlock = nv_access_pkg::UL_LOCKED;
                end else if (wr_acc && hit_unlock) begin
                    if (dat_i[7:0] == nv_access_pkg::UNLOCK_KEY1) begin
                        next_unlock = nv_access_pkg::UL_HALF;
                    end else if (unlock == nv_access_pkg::UL_HALF
                        && dat_i[7:0] == nv_access_pkg::UNLOCK_KEY2) begin
                        next_unlock = nv_access_pkg::UL_OPEN;
                    end else begin
                        next_unlock = nv_access_pkg::UL_LOCKED;
                    end
                end
            end
            default: next_unlock = nv_access_pkg::UL_LOCKED;
        endcase
    end

    wire [CW-1:0] next_cnt = busy ? CW'(cnt + 1'b1) : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= nv_access_pkg::ST_IDLE;
            unlock <= nv_access_pkg::UL_LOCKED;
            cnt <= '0;
        end else begin
            state <= next_state;
            unlock <= next_unlock;
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; address and data ignore bus writes during a write, though a read strobe still loads data
    wire [7:0] next_address = abort ? nv_access_pkg::ADDRESS_RST
        : (wr_acc && hit_address && idle) ? dat_i[7:0] : nv_address;
    wire [7:0] next_data = abort ? nv_access_pkg::DATA_RST
        : rd_strobe ? mem_rdata
        : (wr_acc && hit_data && idle) ? dat_i[7:0] : nv_data_reg;
    wire next_allow = warm ? 1'b0
        : ctrl_write ? dat_i[nv_access_pkg::CTRL_ALLOW] : write_allow;
    wire next_abort_flag = abort ? 1'b1
        : ctrl_write ? dat_i[nv_access_pkg::CTRL_ABORT] : write_abort_flag;
    // zero written to a strobe is not a clear; the strobe lasts one cycle
    wire next_rd = ~warm & ~rd_strobe & ctrl_write & dat_i[nv_access_pkg::CTRL_RD];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_address <= nv_access_pkg::ADDRESS_RST;
            nv_data_reg <= nv_access_pkg::DATA_RST;
            write_allow <= 1'b0;
            write_abort_flag <= 1'b0;
            rd_strobe <= 1'b0;
        end else begin
            nv_address <= next_address;
            nv_data_reg <= next_data;
            write_allow <= next_allow;
            write_abort_flag <= next_abort_flag;
            rd_strobe <= next_rd;
        end
    end

    nv_byte_mem u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(write_done),
        .addr_i(nv_address[nv_access_pkg::MEM_AW-1:0]),
        .wdata_i(nv_data_reg),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // events and interrupt; a new event beats a clearing read
    wire [1:0] events = {abort, write_done};
    wire [1:0] next_flags = events | (peripheral_flag_reg & ~{2{flags_read}});
    wire [1:0] next_mask = (wr_acc && hit_mask) ? dat_i[1:0] : flag_mask;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peripheral_flag_reg <= nv_access_pkg::FLAGS_RST;
            flag_mask <= nv_access_pkg::MASK_RST;
        end else begin
            peripheral_flag_reg <= next_flags;
            flag_mask <= next_mask;
        end
    end

    assign irq_o = |(peripheral_flag_reg & flag_mask);
    assign write_busy_o = busy;

    ////////////////////////////////////////////////////////////////////////////////
    // read path; unlock and unmapped offsets answer zero
    wire [31:0] ctrl_word = {28'h0000000, write_abort_flag, write_allow, wr_bit,
        rd_strobe};
    wire [31:0] rd_mux = hit_address ? {24'h000000, nv_address}
        : hit_control ? ctrl_word
        : hit_data ? {24'h000000, nv_data_reg}
        : hit_flags ? {30'h0, peripheral_flag_reg}
        : hit_mask ? {30'h0, flag_mask}
        : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            dat_o <= rd_acc ? rd_mux : dat_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RD_ONE_CYCLE: assert property (rd_strobe |=> !rd_strobe)
        else $error("read strobe stayed set");

    AST_RD_LOADS: assert property (rd_strobe |=> nv_data_reg == $past(mem_rdata))
        else $error("read did not load data register");

    AST_WR_NEEDS_ALLOW: assert property ($rose(busy) |-> $past(write_allow))
        else $error("write started without write allow");

    AST_WR_CLEARS: assert property ($fell(busy) |-> $past(write_done) || $past(warm))
        else $error("write strobe cleared without completion");

    AST_DONE_FLAG: assert property (write_done |=> !busy && peripheral_flag_reg[0])
        else $error("completion did not set done flag");

    AST_DONE_STICKY: assert property (peripheral_flag_reg[0] && !flags_read
        |=> peripheral_flag_reg[0])
        else $error("done flag dropped without read");

    AST_ABORT: assert property (abort |=> write_abort_flag && nv_address == 8'h00
        && nv_data_reg == 8'h00 && !busy)
        else $error("abort did not flag and clear");

    AST_CTRL_UPPER: assert property (ack_o && !we_i && hit_control
        |-> dat_o[31:4] == 28'h0000000)
        else $error("control upper bits not zero");

    AST_UNLOCK_ZERO: assert property (ack_o && !we_i && hit_unlock
        |-> dat_o == 32'h00000000)
        else $error("unlock register read not zero");

    AST_ALLOW_POR: assert property (@(posedge clk_i) $past(rst_i) |-> !write_allow)
        else $error("write allow set after power up");

    AST_ACK_DROP: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake and read-back
    AST_ACK_NEXT: assert property (req |=> ack_o)
        else $error("request not acknowledged in the next cycle");

    AST_ACK_HAS_REQ: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("acknowledge without a request");

    AST_DAT_HOLD: assert property (!rd_acc |=> $stable(dat_o))
        else $error("read data moved without a read");

    AST_CTRL_LOW: assert property (ack_o && !we_i && hit_control
        |-> dat_o[3:0] == $past({write_abort_flag, write_allow, busy, rd_strobe}))
        else $error("control read-back bits misplaced");

    AST_ADDR_RB: assert property (ack_o && !we_i && hit_address
        |-> dat_o == {24'h000000, $past(nv_address)})
        else $error("address read-back wrong");

    AST_DATA_RB: assert property (ack_o && !we_i && hit_data
        |-> dat_o == {24'h000000, $past(nv_data_reg)})
        else $error("data read-back wrong");

    AST_FLAGS_RB: assert property (ack_o && !we_i && hit_flags
        |-> dat_o == {30'h0, $past(peripheral_flag_reg)})
        else $error("flag read-back wrong");

    AST_MASK_LOAD: assert property (wr_acc && hit_mask |=> flag_mask == $past(dat_i[1:0]))
        else $error("mask write lost");

    AST_MASK_QUIET: assert property (flag_mask == 2'b00 |-> !irq_o)
        else $error("interrupt raised while masked");

    ////////////////////////////////////////////////////////////////////////////////
    // strobes and sequencer
    AST_RD_SET: assert property (ctrl_write && dat_i[nv_access_pkg::CTRL_RD]
        && !warm && !rd_strobe |=> rd_strobe)
        else $error("read strobe not set");

    AST_RD_ZERO: assert property (ctrl_write && !dat_i[nv_access_pkg::CTRL_RD]
        |=> !rd_strobe)
        else $error("zero write raised read strobe");

    AST_WR_KEEP: assert property (busy && !write_done && !warm |=> busy)
        else $error("write cut short without reset");

    AST_WR_UNLOCKED: assert property ($rose(busy)
        |-> $past(unlock) == nv_access_pkg::UL_OPEN)
        else $error("write started while locked");

    AST_KEY_SPENT: assert property (ctrl_write |=> unlock == nv_access_pkg::UL_LOCKED)
        else $error("unlock survived a control write");

    AST_ALLOW_LOAD: assert property (ctrl_write && !warm
        |=> write_allow == $past(dat_i[nv_access_pkg::CTRL_ALLOW]))
        else $error("write allow not loaded");

    AST_CNT_START: assert property ($rose(busy) |-> cnt == '0)
        else $error("write count not fresh");

    AST_CNT_BOUND: assert property (busy |-> cnt <= CNT_LAST)
        else $error("write ran past its count");

    AST_DONE_CAUSE: assert property (
        $rose(peripheral_flag_reg[nv_access_pkg::FLAG_DONE]) |-> $past(write_done))
        else $error("done flag rose with no completed write");

    AST_FLAGS_CLEAR: assert property (flags_read && !write_done && !abort
        |=> peripheral_flag_reg == 2'b00)
        else $error("flag read did not clear");

    // separate tally of busy cycles, so a broken sequencer count shows up
    logic [CW-1:0] busy_run;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_run <= '0;
        end else begin
            busy_run <= busy ? CW'(busy_run + 1'b1) : '0;
        end
    end

    AST_WRITE_CYCLES: assert property (write_done |-> busy_run == CNT_LAST)
        else $error("write did not last its full count");

    ////////////////////////////////////////////////////////////////////////////////
    // warm reset
    AST_WARM_STOP: assert property (warm |=> !busy && !write_allow && !rd_strobe)
        else $error("warm reset left activity running");

    AST_ABORT_EVENT: assert property (abort
        |=> peripheral_flag_reg[nv_access_pkg::FLAG_ABORT])
        else $error("abort event not flagged");

    AST_ABORT_CAUSE: assert property ($rose(write_abort_flag)
        |-> $past(abort) || $past(ctrl_write && dat_i[nv_access_pkg::CTRL_ABORT]))
        else $error("abort flag rose with no cause");

    AST_ADDR_FREEZE: assert property (busy && !abort
        |=> nv_address == $past(nv_address))
        else $error("address moved during a write");

    AST_DATA_FREEZE: assert property (busy && !abort && !rd_strobe
        |=> nv_data_reg == $past(nv_data_reg))
        else $error("data moved during a write");

    COV_READ: cover property (rd_strobe ##1 !rd_strobe);
    COV_WRITE_DONE: cover property (write_done ##1 irq_o);
    COV_ABORT: cover property (abort ##1 write_abort_flag);
    COV_UNLOCK_OPEN: cover property (unlock == nv_access_pkg::UL_OPEN ##1 busy);
    COV_FLAG_CLEAR: cover property (flags_read ##1 !irq_o);
endmodule

// [verification/nv_mem_model.sv]
// behavioural stand-in for the data memory array, used as read reference
`timescale 1ns/100ps
module nv_mem_model (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:nv_access_pkg::MEM_DEPTH-1];
    initial begin
        for (int i = 0; i < nv_access_pkg::MEM_DEPTH; i++) begin
            mem[i] = nv_access_pkg::ERASED_BYTE;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // seven address bits only, so bit 7 aliases onto the low half
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
    assign rdata_o = mem[addr_i];
endmodule

// [verification/testbench.sv]
// self-checking bench for the data memory access block
`timescale 1ns/100ps
module testbench;
    localparam int WC = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext_i = 1'b0;
    logic wdt_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel_v = 4'h1;
    logic [31:0] q;
    logic [31:0] seed = 32'h87c2;
    logic m_we = 1'b0;
    logic [6:0] m_a = 7'h00;
    logic [7:0] m_d = 8'h00;
    wire logic [7:0] m_q;
    wire logic [31:0] dat_o;
    wire logic ack_o;
    wire logic irq_o;
    wire logic busy_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    nv_access_ctrl #(.WRITE_CYCLES(WC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ext_reset_i(ext_i), .wdt_reset_i(wdt_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .write_busy_o(busy_o));
    nv_mem_model ref_mem (.clk_i(clk_i), .we_i(m_we), .addr_i(m_a), .wdata_i(m_d),
        .rdata_o(m_q));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctrl(input logic abort, input logic allow);
        return {28'h0, abort, allow, 2'b00};
    endfunction

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle: request held until ack is sampled, then idle one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= sel_v;
        // no local timeout; besides ack only the global cycle ceiling ends this wait
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic start_write(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, nv_access_pkg::OFS_ADDRESS, {24'h0, a});
        bus(1'b1, nv_access_pkg::OFS_DATA, {24'h0, d});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, ctrl(1'b0, 1'b1));
        bus(1'b1, nv_access_pkg::OFS_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_KEY1});
        bus(1'b1, nv_access_pkg::OFS_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_KEY2});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h6);
    endtask

    task automatic finish_write(input logic [7:0] a, input logic [7:0] d);
        while (busy_o !== 1'b0) begin
            @(posedge clk_i);
        end
        chk("busy", 32'h0, {31'h0, busy_o});
        m_a <= a[6:0];
        m_d <= d;
        m_we <= 1'b1;
        @(posedge clk_i);
        m_we <= 1'b0;
    endtask

    task automatic rd_mem(input logic [7:0] a);
        bus(1'b1, nv_access_pkg::OFS_ADDRESS, {24'h0, a});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h1);
        m_a <= a[6:0];
        rd(nv_access_pkg::OFS_CONTROL, ctrl(1'b0, 1'b0), "control rd");
        rd(nv_access_pkg::OFS_DATA, {24'h0, m_q}, "data");
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [31:0] r;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(nv_access_pkg::OFS_CONTROL, 32'h0, "control reset");
        rd(nv_access_pkg::OFS_UNLOCK, 32'h0, "unlock");
        rd(8'h3c, 32'h0, "unmapped");
        bus(1'b1, nv_access_pkg::OFS_MASK, 32'h1);
        rd(nv_access_pkg::OFS_MASK, 32'h1, "mask");
        // a write without its low byte lane is acked and ignored
        sel_v = 4'h0;
        bus(1'b1, nv_access_pkg::OFS_MASK, 32'h0);
        sel_v = 4'h1;
        rd(nv_access_pkg::OFS_MASK, 32'h1, "mask lane");
        start_write(8'h85, 8'h3c);
        chk("busy on", 32'h1, {31'h0, busy_o});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'hf4);
        chk("busy held", 32'h1, {31'h0, busy_o});
        // address write during the write cycle must be ignored
        bus(1'b1, nv_access_pkg::OFS_ADDRESS, 32'h22);
        finish_write(8'h85, 8'h3c);
        chk("irq", 32'h1, {31'h0, irq_o});
        rd(nv_access_pkg::OFS_CONTROL, ctrl(1'b0, 1'b1), "control");
        rd(nv_access_pkg::OFS_ADDRESS, 32'h85, "address");
        repeat (20) @(posedge clk_i);
        rd(nv_access_pkg::OFS_FLAGS, 32'h1, "flags held");
        chk("irq clear", 32'h0, {31'h0, irq_o});
        rd_mem(8'h05);
        // write attempt with allow clear must not start
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h0);
        bus(1'b1, nv_access_pkg::OFS_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_KEY1});
        bus(1'b1, nv_access_pkg::OFS_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_KEY2});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h2);
        chk("busy blocked", 32'h0, {31'h0, busy_o});
        bus(1'b1, nv_access_pkg::OFS_CONTROL, ctrl(1'b0, 1'b1));
        bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h6);
        chk("busy locked", 32'h0, {31'h0, busy_o});
        rd_mem(8'h05);
        for (int s = 0; s < 2; s++) begin
            start_write(8'h10, 8'h77);
            ext_i <= (s == 0);
            wdt_i <= (s == 1);
            repeat (6) @(posedge clk_i);
            ext_i <= 1'b0;
            wdt_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            rd(nv_access_pkg::OFS_CONTROL, ctrl(1'b1, 1'b0), "abort");
            rd(nv_access_pkg::OFS_ADDRESS, 32'h0, "address cleared");
            rd(nv_access_pkg::OFS_DATA, 32'h0, "data cleared");
            rd(nv_access_pkg::OFS_FLAGS, 32'h2, "abort flag");
            bus(1'b1, nv_access_pkg::OFS_CONTROL, 32'h0);
            rd(nv_access_pkg::OFS_CONTROL, 32'h0, "abort cleared");
        end
        bus(1'b1, nv_access_pkg::OFS_MASK, 32'h0);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            a = {1'b0, r[6:0]};
            r = xs();
            d = r[7:0];
            if (i == 0) begin
                a = 8'h7f;
            end
            start_write(a, d);
            finish_write(a, d);
            chk("irq masked", 32'h0, {31'h0, irq_o});
            rd(nv_access_pkg::OFS_FLAGS, 32'h1, "flags");
            rd_mem(a);
        end
        stop_test();
    end
endmodule
